// file: src/wtsc_pkg.sv
// Constants, encodings and state types for the wireless transmitter status and control block
package wtsc_pkg;

   // Clock and measurement widths
   localparam int CLK_HZ = 25_000_000;
   localparam int ADC_W = 12;
   localparam int BIN_W = 4;
   localparam int NUM_BOUND = 13;

   // Bin boundaries in ADC codes with a 10 uA bias, highest boundary first
   localparam logic [NUM_BOUND*ADC_W-1:0] BIN_BOUNDS = {
      12'hE14, 12'hC39, 12'hA9F, 12'h926, 12'h7EF, 12'h6DE, 12'h5F5,
      12'h528, 12'h477, 12'h3DD, 12'h359, 12'h2E6, 12'h282};

   // Bins with special meaning
   localparam logic [BIN_W-1:0] SCHEME_DARK_BIN = 4'h5;
   localparam logic [BIN_W-1:0] LOSS_OFF_BIN = 4'hD;
   localparam logic [15:0] LOSS_BASE_MW = 16'h00FA;
   localparam logic [15:0] LOSS_STEP_MW = 16'h0032;

   // Coil drive frequency window
   localparam int FREQ_MIN_KHZ = 112;
   localparam int FREQ_MAX_KHZ = 205;
   localparam int PERIOD_MAX_CYC = CLK_HZ / (FREQ_MIN_KHZ * 1000);
   localparam int PERIOD_MIN_CYC = (CLK_HZ + FREQ_MAX_KHZ * 1000 - 1) / (FREQ_MAX_KHZ * 1000);
   localparam logic [7:0] PERIOD_MAX = 8'(PERIOD_MAX_CYC);
   localparam logic [7:0] PERIOD_MIN = 8'(PERIOD_MIN_CYC);
   localparam logic [7:0] HIGH_MIN = 8'h0C;

   // Slow timing, each in its own unit and as cycles
   localparam int SETTLE_MS = 1;
   localparam int SETTLE_CYC = CLK_HZ / 1000 * SETTLE_MS;
   localparam int LIMIT_TICK_MS = 1;
   localparam int LIMIT_TICK_CYC = CLK_HZ / 1000 * LIMIT_TICK_MS;
   localparam int BLINK_HALF_MS = 500;
   localparam int BLINK_HALF_CYC = CLK_HZ / 1000 * BLINK_HALF_MS;
   localparam int BIT_US = 500;
   localparam int BIT_CYC = CLK_HZ / 1_000_000 * BIT_US;

   // Input power limiting thresholds
   localparam logic [ADC_W-1:0] VIN_DROOP_CODE = 12'hA00;
   localparam logic [ADC_W-1:0] IIN_LIMIT_CODE = 12'h1F4;

   // Register byte offsets
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_DRIVE = 8'h08;
   localparam logic [7:0] REG_LOSS = 8'h0C;
   localparam logic [7:0] REG_DEMOD = 8'h10;
   localparam logic [7:0] REG_PACKET = 8'h14;

   // Reset values
   localparam logic [ADC_W-1:0] DEMOD_THR_RST = 12'h800;
   localparam logic [15:0] LOSS_EST_RST = 16'h0000;

   // Packet headers and end-of-transfer code
   localparam logic [7:0] HDR_CTRL_ERR = 8'h03;
   localparam logic [7:0] HDR_END_POWER = 8'h02;
   localparam logic [7:0] EPT_COMPLETE = 8'h01;

   // Indicator codes
   localparam logic [1:0] IND_OFF = 2'b00;
   localparam logic [1:0] IND_ON = 2'b01;
   localparam logic [1:0] IND_BLINK = 2'b10;

   typedef enum logic [1:0] {
      CFG_MEASURE = 2'b01,
      CFG_DONE = 2'b10
   } wtsc_cfg_e;

   typedef enum logic [3:0] {
      OP_STANDBY = 4'b0001,
      OP_TRANSFER = 4'b0010,
      OP_COMPLETE = 4'b0100,
      OP_FAULT = 4'b1000
   } wtsc_op_e;

   typedef enum logic [2:0] {
      PK_HDR = 3'b001,
      PK_MSG = 3'b010,
      PK_SUM = 3'b100
   } wtsc_pk_e;

endpackage

// file: src/wtsc_bin_classify.sv
// Classifies a measured option-pin voltage into a resistor bin
`timescale 1ns/100ps
module wtsc_bin_classify (
   // Measured code
   input wire logic [wtsc_pkg::ADC_W-1:0] code_i,
   // Bin number
   output logic [wtsc_pkg::BIN_W-1:0] bin_o
);
   import wtsc_pkg::*;

   logic [NUM_BOUND-1:0] above;

   // One comparator per bin boundary
   genvar g;
   generate
      for (g = 0; g < NUM_BOUND; g++) begin : g_cmp
         assign above[g] = code_i >= BIN_BOUNDS[g*ADC_W +: ADC_W];
      end
   endgenerate

   // Boundaries rise monotonically, so the count of those passed is the bin
   always_comb begin
      bin_o = '0;
      for (int i = 0; i < NUM_BOUND; i++) begin
         bin_o = bin_o + BIN_W'(above[i]);
      end
   end

endmodule

// file: src/wtsc_demod.sv
// Digital demodulator: coil amplitude samples to received bytes
`timescale 1ns/100ps
module wtsc_demod #(
   parameter int BIT_LEN = wtsc_pkg::BIT_CYC
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Amplitude samples and slicing level
   input wire logic [wtsc_pkg::ADC_W-1:0] amp_i,
   input wire logic [wtsc_pkg::ADC_W-1:0] thr_i,
   // Received bytes
   output logic [7:0] byte_o,
   output logic byte_valid_o,
   output logic frame_err_o
);
   import wtsc_pkg::*;

   logic level_q, busy_q;
   logic [15:0] tmr_q;
   logic [3:0] idx_q;
   logic [8:0] shift_q;

   // Slice the amplitude; a raised amplitude means the receiver is modulating
   always_ff @(posedge clk_i) begin
      if (rst_i) level_q <= 1'b0;
      else level_q <= amp_i > thr_i;
   end

   // Byte framing: start 1, eight data bits LSB first, odd parity, stop 0
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         busy_q <= 1'b0;
         tmr_q <= 16'h0000;
         idx_q <= 4'h0;
         shift_q <= 9'h000;
         byte_o <= 8'h00;
         byte_valid_o <= 1'b0;
         frame_err_o <= 1'b0;
      end else begin
         byte_valid_o <= 1'b0;
         frame_err_o <= 1'b0;
         if (!busy_q) begin
            if (level_q) begin
               busy_q <= 1'b1;
               tmr_q <= 16'(BIT_LEN / 2);   // Sample mid-bit for margin against slow edges
               idx_q <= 4'h0;
            end
         end else if (tmr_q != 16'h0000) begin
            tmr_q <= tmr_q - 16'h0001;
         end else begin
            tmr_q <= 16'(BIT_LEN - 1);
            idx_q <= idx_q + 4'h1;
            if (idx_q == 4'h0 && !level_q) begin
               busy_q <= 1'b0;   // Glitch, not a start bit
            end else if (idx_q >= 4'h1 && idx_q <= 4'h9) begin
               shift_q <= {level_q, shift_q[8:1]};
            end else if (idx_q == 4'hA) begin
               busy_q <= 1'b0;
               if (!level_q && ^shift_q) begin
                  byte_o <= shift_q[7:0];
                  byte_valid_o <= 1'b1;
               end else begin
                  frame_err_o <= 1'b1;
               end
            end
         end
      end
   end

endmodule

// file: src/wtsc_top.sv
// Status indication and power control of a wireless power transmitter
// What this block does
// - Bias option pins at power-up, classify resistors
// - Loss-threshold bin sets object detection limit
// - Scheme bin picks the indicator behaviour
// - Scheme at 75k or above: indicators dark
// - Scheme 1 indicator pattern per state
// - Scheme 3 indicator pattern per state
// - Mode pin selects droop or constant-current limiting
// - Droop mode cuts power on input sag
// - Current mode keeps input below 500 mA
// - Show limiting on indicators per scheme
// - Negative control error still obeyed while limiting
// - Frequency 112-205 kHz, higher means less power
// - Duty 50%, cut only at 205 kHz
// - Receiver-to-transmitter only; requests steer frequency
// - Demodulate packets digitally from coil amplitude
// - Loss above threshold flags fault, stops transfer
//
// The implementer's own choices: register access over Wishbone and the placing of the registers.
`timescale 1ns/100ps
module wtsc_top #(
   parameter int SETTLE_LEN = wtsc_pkg::SETTLE_CYC,
   parameter int LIMIT_TICK_LEN = wtsc_pkg::LIMIT_TICK_CYC,
   parameter int BLINK_HALF_LEN = wtsc_pkg::BLINK_HALF_CYC,
   parameter int BIT_LEN = wtsc_pkg::BIT_CYC
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Option pin measurement
   input wire logic [wtsc_pkg::ADC_W-1:0] indication_scheme_select_i,
   input wire logic [wtsc_pkg::ADC_W-1:0] loss_threshold_select_i,
   output logic bias_en_o,
   // Supply monitoring and limiting mode pin
   input wire logic [wtsc_pkg::ADC_W-1:0] vin_sample_i,
   input wire logic [wtsc_pkg::ADC_W-1:0] iin_sample_i,
   input wire logic limit_mode_pin_i,
   // Coil amplitude for demodulation
   input wire logic [wtsc_pkg::ADC_W-1:0] coil_amp_i,
   // Coil drive and indicators
   output logic coil_drive_o,
   output logic drive_enable_o,
   output logic green_indicator_out_o,
   output logic red_indicator_out_o,
   output logic input_power_limiting_o,
   output logic fault_o
);
   import wtsc_pkg::*;

   wtsc_cfg_e cfg_q;
   wtsc_op_e op_q;
   wtsc_pk_e pk_q;
   logic [23:0] settle_q, tick_q, blink_cnt_q;
   logic [BIN_W-1:0] scheme_bin_q, loss_bin_q, scheme_bin_d, loss_bin_d;
   logic [15:0] loss_threshold_select_q, loss_est_q;
   logic [ADC_W-1:0] demod_thr_q;
   logic tx_enable_q, fault_clear_q, ack_q;
   logic mode_meta_q, mode_q;
   logic limiting_q, limit_tick_q, blink_q;
   logic [7:0] period_q, high_q, phase_q;
   logic [7:0] hdr_q, msg_q, rx_byte;
   logic rx_valid, rx_err, pkt_ok_q;
   logic [7:0] last_hdr_q, last_msg_q;
   logic wb_req, wb_wr;
   logic loss_over, more_power, less_power;
   logic [3:0] ind_codes;

   //////////////////////////////////////////////////////////////////////////
   // Option pins

   wtsc_bin_classify u_scheme_bin (
      .code_i(indication_scheme_select_i),
      .bin_o(scheme_bin_d)
   );

   wtsc_bin_classify u_loss_bin (
      .code_i(loss_threshold_select_i),
      .bin_o(loss_bin_d)
   );

   // Bias both pins, let the voltage settle, then latch both bins once
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cfg_q <= CFG_MEASURE;
         settle_q <= 24'h00_0000;
         bias_en_o <= 1'b1;
         scheme_bin_q <= '0;
         loss_bin_q <= '0;
      end else begin
         case (cfg_q)
            CFG_MEASURE: begin
               if (settle_q == 24'(SETTLE_LEN - 1)) begin
                  scheme_bin_q <= scheme_bin_d;
                  loss_bin_q <= loss_bin_d;
                  bias_en_o <= 1'b0;
                  cfg_q <= CFG_DONE;
               end else begin
                  settle_q <= settle_q + 24'h00_0001;
               end
            end
            CFG_DONE: cfg_q <= CFG_DONE;
            default: cfg_q <= CFG_MEASURE;
         endcase
      end
   end

   // Loss threshold in mW from the bin
   always_ff @(posedge clk_i) begin
      if (rst_i) loss_threshold_select_q <= LOSS_BASE_MW;
      else loss_threshold_select_q <= LOSS_BASE_MW + 16'(loss_bin_q * LOSS_STEP_MW);
   end

   // The last bin turns detection off
   assign loss_over = (loss_bin_q != LOSS_OFF_BIN) && (loss_est_q > loss_threshold_select_q);

   //////////////////////////////////////////////////////////////////////////
   // Wishbone slave

   assign wb_req = wb_cyc_i && wb_stb_i && !ack_q;
   assign wb_wr = wb_cyc_i && wb_stb_i && wb_we_i && ack_q;

   // One wait state; writes land at the edge where the master sees ack
   always_ff @(posedge clk_i) begin
      if (rst_i) ack_q <= 1'b0;
      else ack_q <= wb_req;
   end
   assign wb_ack_o = ack_q;

   // Writable registers; unmapped writes are acknowledged and dropped
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tx_enable_q <= 1'b0;
         fault_clear_q <= 1'b0;
         loss_est_q <= LOSS_EST_RST;
         demod_thr_q <= DEMOD_THR_RST;
      end else begin
         fault_clear_q <= 1'b0;
         if (wb_wr && wb_adr_i == REG_CTRL && wb_sel_i[0]) begin
            tx_enable_q <= wb_dat_i[0];
            fault_clear_q <= wb_dat_i[1];
         end
         if (wb_wr && wb_adr_i == REG_LOSS) begin
            if (wb_sel_i[0]) loss_est_q[7:0] <= wb_dat_i[7:0];
            if (wb_sel_i[1]) loss_est_q[15:8] <= wb_dat_i[15:8];
         end
         if (wb_wr && wb_adr_i == REG_DEMOD) begin
            if (wb_sel_i[0]) demod_thr_q[7:0] <= wb_dat_i[7:0];
            if (wb_sel_i[1]) demod_thr_q[11:8] <= wb_dat_i[11:8];
         end
      end
   end

   // Read data, registered with the ack; unmapped reads return zero
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_dat_o <= 32'h0000_0000;
      end else if (wb_req && !wb_we_i) begin
         case (wb_adr_i)
            REG_CTRL: wb_dat_o <= {31'h0000_0000, tx_enable_q};
            REG_STATUS: wb_dat_o <= {17'h0_0000, cfg_q == CFG_DONE, mode_q, limiting_q,
                                     op_q, loss_bin_q, scheme_bin_q};
            REG_DRIVE: wb_dat_o <= {16'h0000, high_q, period_q};
            REG_LOSS: wb_dat_o <= {16'h0000, loss_est_q};
            REG_DEMOD: wb_dat_o <= {20'h0_0000, demod_thr_q};
            REG_PACKET: wb_dat_o <= {16'h0000, last_msg_q, last_hdr_q};
            default: wb_dat_o <= 32'h0000_0000;
         endcase
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Input power limiting

   // Mode pin is asynchronous: two flops before use
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mode_meta_q <= 1'b0;
         mode_q <= 1'b0;
      end else begin
         mode_meta_q <= limit_mode_pin_i;
         mode_q <= mode_meta_q;
      end
   end

   // Low mode pin: droop mode; high: constant-current mode
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         limiting_q <= 1'b0;
      end else if (!mode_q) begin
         limiting_q <= vin_sample_i < VIN_DROOP_CODE;
      end else begin
         limiting_q <= iin_sample_i >= IIN_LIMIT_CODE;
      end
   end
   assign input_power_limiting_o = limiting_q;

   // Limiting steps slowly so the receiver loop is not fought on every cycle
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tick_q <= 24'h00_0000;
         limit_tick_q <= 1'b0;
      end else begin
         limit_tick_q <= tick_q == 24'(LIMIT_TICK_LEN - 1);
         if (tick_q == 24'(LIMIT_TICK_LEN - 1)) tick_q <= 24'h00_0000;
         else tick_q <= tick_q + 24'h00_0001;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Packet reception

   wtsc_demod #(
      .BIT_LEN(BIT_LEN)
   ) u_demod (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .amp_i(coil_amp_i),
      .thr_i(demod_thr_q),
      .byte_o(rx_byte),
      .byte_valid_o(rx_valid),
      .frame_err_o(rx_err)
   );

   // Header, message, checksum; preamble ones look like start bits and end in framing errors, which return to the header
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pk_q <= PK_HDR;
         hdr_q <= 8'h00;
         msg_q <= 8'h00;
         pkt_ok_q <= 1'b0;
         last_hdr_q <= 8'h00;
         last_msg_q <= 8'h00;
      end else begin
         pkt_ok_q <= 1'b0;
         if (rx_err) begin
            pk_q <= PK_HDR;
         end else if (rx_valid) begin
            case (pk_q)
               PK_HDR: begin
                  hdr_q <= rx_byte;
                  pk_q <= PK_MSG;
               end
               PK_MSG: begin
                  msg_q <= rx_byte;
                  pk_q <= PK_SUM;
               end
               PK_SUM: begin
                  pk_q <= PK_HDR;
                  if (rx_byte == (hdr_q ^ msg_q)) begin
                     pkt_ok_q <= 1'b1;
                     last_hdr_q <= hdr_q;
                     last_msg_q <= msg_q;
                  end
               end
               default: pk_q <= PK_HDR;
            endcase
         end
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Operating state

   // Fault set wins over a clear in the same cycle
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         op_q <= OP_STANDBY;
      end else begin
         case (op_q)
            OP_STANDBY: begin
               if (tx_enable_q && pkt_ok_q && cfg_q == CFG_DONE) op_q <= OP_TRANSFER;
            end
            OP_TRANSFER: begin
               if (loss_over) begin
                  op_q <= OP_FAULT;
               end else if (!tx_enable_q) begin
                  op_q <= OP_STANDBY;
               end else if (pkt_ok_q && hdr_q == HDR_END_POWER) begin
                  op_q <= (msg_q == EPT_COMPLETE) ? OP_COMPLETE : OP_STANDBY;
               end
            end
            OP_COMPLETE: begin
               if (!tx_enable_q) op_q <= OP_STANDBY;
            end
            OP_FAULT: begin
               if (fault_clear_q && !loss_over) op_q <= OP_STANDBY;
            end
            default: op_q <= OP_STANDBY;
         endcase
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Coil drive

   // Requests only come from the receiver; limiting forces power down
   assign more_power = pkt_ok_q && hdr_q == HDR_CTRL_ERR && !msg_q[7] && msg_q != 8'h00
                       && !limiting_q;
   assign less_power = (pkt_ok_q && hdr_q == HDR_CTRL_ERR && msg_q[7])
                       || (limiting_q && limit_tick_q);

   // Frequency moves first; duty is shaved only when pinned at the top
   always_ff @(posedge clk_i) begin
      if (rst_i || op_q != OP_TRANSFER) begin
         period_q <= PERIOD_MAX;
         high_q <= PERIOD_MAX >> 1;
      end else if (less_power) begin
         if (period_q > PERIOD_MIN) begin
            period_q <= period_q - 8'h01;
            high_q <= (period_q - 8'h01) >> 1;
         end else if (high_q > HIGH_MIN) begin
            high_q <= high_q - 8'h01;
         end
      end else if (more_power) begin
         if (high_q < (period_q >> 1)) begin
            high_q <= high_q + 8'h01;
         end else if (period_q < PERIOD_MAX) begin
            period_q <= period_q + 8'h01;
            high_q <= (period_q + 8'h01) >> 1;
         end
      end
   end

   // Drive waveform; pings in standby, silent in fault and complete
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         phase_q <= 8'h00;
         coil_drive_o <= 1'b0;
         drive_enable_o <= 1'b0;
      end else begin
         drive_enable_o <= tx_enable_q && (op_q == OP_STANDBY || op_q == OP_TRANSFER);
         phase_q <= (phase_q >= period_q - 8'h01) ? 8'h00 : phase_q + 8'h01;
         coil_drive_o <= drive_enable_o && phase_q < high_q;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Indicators

   // Slow blink divider
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         blink_cnt_q <= 24'h00_0000;
         blink_q <= 1'b0;
      end else if (blink_cnt_q == 24'(BLINK_HALF_LEN - 1)) begin
         blink_cnt_q <= 24'h00_0000;
         blink_q <= !blink_q;
      end else begin
         blink_cnt_q <= blink_cnt_q + 24'h00_0001;
      end
   end

   // Indicator codes {green, red} per scheme, state and limiting
   function automatic logic [3:0] ind_table(input logic [BIN_W-1:0] bin,
                                            input wtsc_op_e op, input logic lim);
      ind_table = {IND_OFF, IND_OFF};
      case (bin)
         4'h1: begin
            if (lim) ind_table = {IND_BLINK, IND_BLINK};
            else if (op == OP_TRANSFER) ind_table = {IND_BLINK, IND_OFF};
            else if (op == OP_COMPLETE) ind_table = {IND_ON, IND_OFF};
            else if (op == OP_FAULT) ind_table = {IND_OFF, IND_ON};
         end
         4'h2: begin
            if (lim) ind_table = {IND_BLINK, IND_BLINK};
            else if (op == OP_STANDBY) ind_table = {IND_ON, IND_ON};
            else if (op == OP_TRANSFER) ind_table = {IND_BLINK, IND_OFF};
            else if (op == OP_COMPLETE) ind_table = {IND_ON, IND_OFF};
            else ind_table = {IND_OFF, IND_ON};
         end
         4'h3: begin
            if (lim) ind_table = {IND_OFF, IND_ON};
            else if (op == OP_TRANSFER) ind_table = {IND_OFF, IND_ON};
            else if (op == OP_COMPLETE) ind_table = {IND_ON, IND_OFF};
            else if (op == OP_FAULT) ind_table = {IND_OFF, IND_BLINK};
         end
         4'h4: begin
            if (lim) ind_table = {IND_OFF, IND_BLINK};
            else if (op == OP_TRANSFER) ind_table = {IND_ON, IND_OFF};
            else if (op == OP_FAULT) ind_table = {IND_OFF, IND_ON};
         end
         default: ind_table = {IND_OFF, IND_OFF};
      endcase
   endfunction

   // Limiting shows only while power is actually being transferred
   assign ind_codes = ind_table(scheme_bin_q, op_q,
                                limiting_q && op_q == OP_TRANSFER);

   // Dark until configuration is latched
   always_ff @(posedge clk_i) begin
      if (rst_i || cfg_q != CFG_DONE) begin
         green_indicator_out_o <= 1'b0;
         red_indicator_out_o <= 1'b0;
      end else begin
         green_indicator_out_o <= ind_codes[2] | (ind_codes[3] & blink_q);
         red_indicator_out_o <= ind_codes[0] | (ind_codes[1] & blink_q);
      end
   end

   // Fault flag mirrors the state
   always_ff @(posedge clk_i) begin
      if (rst_i) fault_o <= 1'b0;
      else fault_o <= op_q == OP_FAULT;
   end

endmodule

// file: tb/wtsc_top_properties.sv
// Port-level assertions for the wireless transmitter status block
`timescale 1ns/100ps
module wtsc_top_properties (
   // Clock, reset and bus
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   // Status outputs
   input wire logic bias_en_o,
   input wire logic coil_drive_o,
   input wire logic drive_enable_o,
   input wire logic green_indicator_out_o,
   input wire logic red_indicator_out_o,
   input wire logic fault_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // Bus answers one cycle after taking, for exactly one cycle
   a_ack_delay: assert property
      (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack missing");
   a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
   a_data_hold: assert property ($changed(wb_dat_o) |-> wb_ack_o) else $error("data moved");
   // Option pins are biased once, and indicators wait for the latched scheme
   a_bias_once: assert property (!bias_en_o |=> !bias_en_o) else $error("bias back");
   a_cfg_dark: assert property
      (bias_en_o |-> !green_indicator_out_o && !red_indicator_out_o) else $error("early lamp");
   // One cycle of slack allowed (two for the coil), since fault and drive are separate registers
   a_fault_nodrive: assert property
      (fault_o [*2] |-> !drive_enable_o) else $error("drive in fault");
   a_fault_green: assert property
      (fault_o && $past(fault_o) |-> !green_indicator_out_o) else $error("green in fault");
   a_coil_quiet: assert property
      (!drive_enable_o [*3] |-> !coil_drive_o) else $error("coil driven");
endmodule
////////////////////////////////////////////////////////////
bind wtsc_top wtsc_top_properties chk_u (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_dat_o,
   .wb_ack_o, .bias_en_o, .coil_drive_o, .drive_enable_o, .green_indicator_out_o,
   .red_indicator_out_o, .fault_o);

// file: tb/wtsc_rx_model.sv
// Receiver model: modulates the coil amplitude with framed packets
`timescale 1ns/100ps
module wtsc_rx_model #(
   parameter int BIT_LEN = 8
) (
   // Clock
   input wire logic clk_i,
   // Modulated coil amplitude
   output logic [11:0] coil_amp_o
);
   // Unmodulated coil rests below the slicing level
   initial coil_amp_o = 12'h0400;
   // Start, data LSB first, odd parity, stop
   task automatic send_byte(input logic [7:0] b);
      logic [10:0] f;
      f = {1'b0, ~^b, b, 1'b1};
      for (int i = 0; i < 11; i++) begin
         coil_amp_o <= f[i] ? 12'h0C00 : 12'h0400;
         repeat (BIT_LEN) @(posedge clk_i);
      end
   endtask
   // Receiver only ever talks; gap models a slow sender
   task automatic send(input logic [7:0] h, input logic [7:0] m, input int gap);
      repeat (gap) @(posedge clk_i);
      send_byte(h);
      send_byte(m);
      send_byte(h ^ m);
   endtask
endmodule

// file: tb/wtsc_top_tb_top.sv
// Self-checking bench for the wireless transmitter status block
`timescale 1ns/100ps
module wtsc_top_tb_top;
   import wtsc_pkg::*;
   logic clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
   logic [7:0] wb_adr_i = 8'h00;
   logic [3:0] wb_sel_i = 4'hF;
   logic [31:0] wb_dat_i = 32'h0000_0000, wb_dat_o, rd;
   logic [11:0] indication_scheme_select_i = 12'h0380, loss_threshold_select_i = 12'h0380;
   logic [11:0] vin_sample_i = 12'h0C00, iin_sample_i = 12'h0000, coil_amp_i;
   logic limit_mode_pin_i = 1'b0, wb_ack_o, bias_en_o, coil_drive_o, drive_enable_o, r0;
   logic green_indicator_out_o, red_indicator_out_o, input_power_limiting_o, fault_o;
   int errors = 0, total_checks = 0;
   // Short counts keep the run brief; expectations follow them
   wtsc_top #(.SETTLE_LEN(4), .LIMIT_TICK_LEN(8), .BLINK_HALF_LEN(4), .BIT_LEN(8)) dut_u (
      .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
      .wb_dat_o, .wb_ack_o, .indication_scheme_select_i, .loss_threshold_select_i,
      .bias_en_o, .vin_sample_i, .iin_sample_i, .limit_mode_pin_i, .coil_amp_i,
      .coil_drive_o, .drive_enable_o, .green_indicator_out_o, .red_indicator_out_o,
      .input_power_limiting_o, .fault_o);
   wtsc_rx_model #(.BIT_LEN(8)) rx_u (.clk_i, .coil_amp_o(coil_amp_i));
   // 25 MHz clock
   initial forever #20 clk_i = ~clk_i;
   ////////////////////////////////////////////////////////////
   task automatic conclude;
      $display("checks %0d mismatches %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      total_checks++;
      if (s !== e) begin
         errors++;
         $display("mismatch at %0t: saw %h expected %h", $time, s, e);
      end
   endtask
   // Classic cycle; the wait is bounded so a dead slave ends the run
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, w, a, d};
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 50);
      rd = wb_dat_o;
      {wb_cyc_i, wb_stb_i} <= 2'b00;
      if (n >= 50) begin
         errors++;
         conclude;
      end
   endtask
   task automatic settle(input int n);
      repeat (n) @(posedge clk_i);
   endtask
   // Reset with a chosen scheme; never a reserved low bin
   task automatic start(input logic [11:0] s);
      rst_i <= 1'b1;
      indication_scheme_select_i <= s;
      settle(8);
      rst_i <= 1'b0;
      settle(1);
      chk(bias_en_o, 1);
      settle(6);
      chk(bias_en_o, 0);
   endtask
   // Main sequence: scheme 3, loss bin 3, then scheme 2 and the dark scheme
   initial begin
      start(12'h0380);
      wb(0, REG_STATUS, 0);
      chk(rd, 32'h0000_4133);
      wb(0, REG_DEMOD, 0);
      chk(rd, 32'h0000_0800);
      wb(0, 8'h20, 0);
      chk(rd, 0);
      chk({green_indicator_out_o, red_indicator_out_o}, 2'b00);
      wb(1, REG_CTRL, 1);
      rx_u.send(HDR_CTRL_ERR, 8'h00, 0);
      settle(3);
      chk({green_indicator_out_o, red_indicator_out_o, drive_enable_o}, 3'b011);
      wb(0, REG_DRIVE, 0);
      chk(rd, 32'h0000_6FDF);
      rx_u.send(HDR_CTRL_ERR, 8'hFF, 5);
      wb(0, REG_DRIVE, 0);
      chk(rd[7:0], 8'hDE);
      rx_u.send(HDR_CTRL_ERR, 8'h01, 0);
      wb(0, REG_DRIVE, 0);
      chk(rd[7:0], 8'hDF);
      $display("test packets done");
      limit_mode_pin_i <= 1'b1;
      iin_sample_i <= 12'h01F4;
      settle(20);
      chk({input_power_limiting_o, red_indicator_out_o}, 2'b11);
      chk(green_indicator_out_o, 0);
      wb(0, REG_DRIVE, 0);
      chk(rd[7:0] < 8'hDF, 1);
      {limit_mode_pin_i, iin_sample_i, vin_sample_i} <= {1'b0, 12'h0000, 12'h0900};
      settle(20);
      chk(input_power_limiting_o, 1);
      vin_sample_i <= 12'h0C00;
      settle(20);
      chk(input_power_limiting_o, 0);
      $display("test limiting done");
      wb(1, REG_LOSS, 32'h0000_0190);
      settle(4);
      chk(fault_o, 0);
      wb(1, REG_LOSS, 32'h0000_0191);
      settle(4);
      chk({fault_o, drive_enable_o, coil_drive_o}, 3'b100);
      r0 = red_indicator_out_o;
      settle(4);
      chk(red_indicator_out_o, !r0);
      $display("test fault done");
      start(12'h0300);
      chk({green_indicator_out_o, red_indicator_out_o}, 2'b11);
      start(12'h04A0);
      wb(1, REG_CTRL, 1);
      rx_u.send(HDR_CTRL_ERR, 8'h00, 0);
      settle(3);
      chk({green_indicator_out_o, red_indicator_out_o, drive_enable_o}, 3'b001);
      $display("test dark scheme done");
      conclude;
   end
endmodule
